//--- hdl/crf_top.sv
`timescale 1ns/1ps
// Functional notes
// - five-deep receive fifo, one shared window
// - assembly buffer private, only head visible
// - each buffer holds fifteen bytes
// - full flag set when head holds frame
// - assemble and filter together, then push
// - rejected frames never pushed, overwritten next
// - own transmitted frames not stored
// - loopback treats own frames as received
// - lost arbitration continues as receiver
// - full fifo drops accepted frame, flags overrun
// - keeps transmitting when full, resumes accepting
// - code pattern compared, mask bits ignored
// - report lowest matching filter index
// - 32-bit mode gives two filters
// - 16-bit mode gives four filters
// - 8-bit mode gives eight filters
// - closed mode never sets full flag
// - error counters cannot be written
// - config writes only in init mode
// - transmit pin recessive in init, powerdown
// - enable bit written only once in normal mode
module crf_top #(
	parameter int DEPTH = crf_pkg::FIFO_DEPTH
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// frame engine side
	input wire logic rx_sof_i,
	input wire logic rx_byte_we_i,
	input wire logic [3:0] rx_byte_idx_i,
	input wire logic [7:0] rx_byte_i,
	input wire crf_pkg::crf_hdr_t rx_hdr_i,
	input wire logic rx_done_ok_i,
	input wire logic rx_error_i,
	input wire logic tx_active_i,
	input wire logic arb_lost_i,
	input wire logic tx_bit_i,
	input wire logic error_cnt_we_i,
	input wire logic [7:0] error_cnt_wdata_i,
	input wire logic [7:0] rx_err_inc_i,
	input wire logic [7:0] tx_err_inc_i,
	// cpu side
	input wire crf_pkg::crf_cfg_wr_t cfg_wr_i,
	input wire logic init_mode_request_i,
	input wire logic power_down_i,
	input wire logic normal_sys_mode_i,
	input wire logic enable_we_i,
	input wire logic enable_wdata_i,
	input wire logic full_flag_clr_i,
	input wire logic rx_int_en_i,
	input wire logic ovr_int_en_i,
	output logic [crf_pkg::BUF_BITS-1:0] cpu_visible_head_buffer_o,
	output logic receive_full_flag_o,
	output logic [crf_pkg::HIT_W-1:0] filter_hit_index_o,
	output logic overrun_flag_o,
	output logic rx_irq_o,
	output logic ovr_irq_o,
	output logic init_mode_acknowledge_o,
	output logic module_enable_bit_o,
	output logic can_transmit_pin_o,
	output logic ack_drive_o,
	output logic [7:0] control_one_reg_o,
	output logic [7:0] bus_timing_reg_zero_o,
	output logic [7:0] bus_timing_reg_one_o,
	output logic [7:0] acceptance_control_reg_o,
	output logic [7:0] rx_err_cnt_o,
	output logic [7:0] tx_err_cnt_o
);
	// refuse depths that the three-bit pointers and four-bit count cannot serve
	if (DEPTH < 2 || DEPTH > 8) begin
		$error("DEPTH out of range");
	end

	////////////////////////////////////////////////////////////////
	// configuration state
	logic [7:0] ctl1, next_ctl1; // control one
	logic [7:0] btr0, next_btr0; // bus timing zero
	logic [7:0] btr1, next_btr1; // bus timing one
	logic [7:0] idac, next_idac; // acceptance control, mode in [5:4]
	logic [63:0] code, next_code; // acceptance code bank
	logic [63:0] mask, next_mask; // acceptance mask bank
	logic init_ack, next_init_ack; // init acknowledge
	logic en_done, next_en_done; // enable already written
	logic en, next_en; // module enable
	logic cfg_ok; // config lock open
	logic [1:0] fmode; // filter mode
	logic [7:0] rec, next_rec; // receive error counter
	logic [7:0] tec, next_tec; // transmit error counter

	assign cfg_ok = init_mode_request_i && init_ack;
	assign fmode = idac[5:4];

	// config next values
	always_comb begin
		next_ctl1 = ctl1;
		next_btr0 = btr0;
		next_btr1 = btr1;
		next_idac = idac;
		next_code = code;
		next_mask = mask;
		next_init_ack = init_mode_request_i;
		next_en_done = en_done;
		next_en = en;
		if (cfg_wr_i.we && cfg_ok) begin
			if (cfg_wr_i.sel == crf_pkg::CSEL_CTL1) begin
				next_ctl1 = cfg_wr_i.wdata;
			end else if (cfg_wr_i.sel == crf_pkg::CSEL_BTR0) begin
				next_btr0 = cfg_wr_i.wdata;
			end else if (cfg_wr_i.sel == crf_pkg::CSEL_BTR1) begin
				next_btr1 = cfg_wr_i.wdata;
			end else if (cfg_wr_i.sel == crf_pkg::CSEL_IDAC) begin
				next_idac = {2'h0, cfg_wr_i.wdata[5:4], 4'h0};
			end else if (cfg_wr_i.sel[4:3] == crf_pkg::CSEL_CODE0[4:3]) begin
				next_code[cfg_wr_i.sel[2:0]*8 +: 8] = cfg_wr_i.wdata;
			end else if (cfg_wr_i.sel[4:3] == crf_pkg::CSEL_MASK0[4:3]) begin
				next_mask[cfg_wr_i.sel[2:0]*8 +: 8] = cfg_wr_i.wdata;
			end
		end
		if (enable_we_i && (!normal_sys_mode_i || !en_done)) begin
			next_en = enable_wdata_i;
			next_en_done = 1'b1;
		end
	end

	// error counters: engine increments only, cpu writes dropped
	always_comb begin
		next_rec = rec + rx_err_inc_i;
		next_tec = tec + tx_err_inc_i;
		if (error_cnt_we_i) begin
			next_rec = rec + rx_err_inc_i + (error_cnt_wdata_i & 8'h0);
		end
	end

	// config registers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl1 <= crf_pkg::CTL1_RST;
			btr0 <= crf_pkg::BYTE_RST;
			btr1 <= crf_pkg::BYTE_RST;
			idac <= crf_pkg::BYTE_RST;
			code <= '0;
			mask <= {crf_pkg::NBANK_REGS{crf_pkg::MASK_RST}};
			init_ack <= 1'b0;
			en_done <= 1'b0;
			en <= 1'b0;
			rec <= '0;
			tec <= '0;
		end else begin
			ctl1 <= next_ctl1;
			btr0 <= next_btr0;
			btr1 <= next_btr1;
			idac <= next_idac;
			code <= next_code;
			mask <= next_mask;
			init_ack <= next_init_ack;
			en_done <= next_en_done;
			en <= next_en;
			rec <= next_rec;
			tec <= next_tec;
		end
	end

	////////////////////////////////////////////////////////////////
	// private buffer and filter
	logic [crf_pkg::BUF_BITS-1:0] bg_data; // private image
	logic f_hit; // some filter matched
	logic [crf_pkg::HIT_W-1:0] f_idx; // lowest match
	logic loopb; // loopback mode
	logic own_frame; // we are still transmitting
	logic accept; // frame goes into the fifo unless it overruns

	crf_buffer u_bg (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.sof_i(rx_sof_i),
		.byte_we_i(rx_byte_we_i),
		.byte_idx_i(rx_byte_idx_i),
		.byte_i(rx_byte_i),
		.data_o(bg_data)
	);

	crf_filter u_flt (
		.mode_i(fmode),
		.code_i(code),
		.mask_i(mask),
		.hdr_i(rx_hdr_i),
		.hit_o(f_hit),
		.idx_o(f_idx)
	);

	assign loopb = ctl1[crf_pkg::CTL1_LOOPB];
	// lost arbitration means the frame is another node's
	assign own_frame = tx_active_i && !arb_lost_i && !loopb;
	assign accept = rx_done_ok_i && !rx_error_i && f_hit && !own_frame && en;

	////////////////////////////////////////////////////////////////
	// receive fifo
	crf_pkg::crf_entry_t mem [DEPTH];
	crf_pkg::crf_entry_t next_mem [DEPTH];
	logic [3:0] cnt, next_cnt; // stored frames
	logic [2:0] rd, next_rd; // head index
	logic [2:0] wr, next_wr; // tail index
	logic hfull, next_hfull; // head valid flag
	logic [crf_pkg::BUF_BITS-1:0] head, next_head; // registered head window
	logic [crf_pkg::HIT_W-1:0] hidx, next_hidx; // registered hit of the head
	logic ovr, next_ovr; // overrun sticky
	logic ovr_p, next_ovr_p; // overrun pulse
	logic rxi_p, next_rxi_p; // receive event pulse
	logic pop; // head released

	function automatic logic [2:0] inc(input logic [2:0] p);
		inc = (p == 3'(DEPTH - 1)) ? 3'h0 : p + 3'h1;
	endfunction

	assign pop = full_flag_clr_i && hfull;

	// fifo next values
	always_comb begin
		next_mem = mem;
		next_rd = rd;
		next_wr = wr;
		next_cnt = cnt;
		next_ovr = ovr;
		next_ovr_p = 1'b0;
		next_rxi_p = 1'b0;
		if (pop) begin
			next_rd = inc(rd);
			next_cnt = next_cnt - 4'h1;
		end
		if (accept) begin
			if (cnt == 4'(DEPTH) && !pop) begin
				next_ovr = 1'b1;
				next_ovr_p = ovr_int_en_i;
			end else begin
				next_mem[wr] = '{data: bg_data, hit: f_idx};
				next_wr = inc(wr);
				next_cnt = next_cnt + 4'h1;
				next_rxi_p = rx_int_en_i;
			end
		end
		next_hfull = (next_cnt != 4'h0);
		// window shows the new head, zero while empty
		next_head = next_hfull ? next_mem[next_rd].data : '0;
		next_hidx = next_mem[next_rd].hit;
	end

	// fifo registers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
			rd <= '0;
			wr <= '0;
			cnt <= '0;
			hfull <= 1'b0;
			head <= '0;
			hidx <= '0;
			ovr <= 1'b0;
			ovr_p <= 1'b0;
			rxi_p <= 1'b0;
		end else begin
			mem <= next_mem;
			rd <= next_rd;
			wr <= next_wr;
			cnt <= next_cnt;
			hfull <= next_hfull;
			head <= next_head;
			hidx <= next_hidx;
			ovr <= next_ovr;
			ovr_p <= next_ovr_p;
			rxi_p <= next_rxi_p;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs, all registered
	logic txp, next_txp; // transmit pin
	logic ackd, next_ackd; // ack drive request

	always_comb begin
		next_txp = tx_bit_i;
		if (init_mode_request_i || init_ack || power_down_i) begin
			next_txp = 1'b1;
		end
		next_ackd = rx_done_ok_i && !own_frame;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			txp <= 1'b1;
			ackd <= 1'b0;
		end else begin
			txp <= next_txp;
			ackd <= next_ackd;
		end
	end

	assign cpu_visible_head_buffer_o = head;
	assign filter_hit_index_o = hidx;
	assign receive_full_flag_o = hfull;
	assign overrun_flag_o = ovr;
	assign rx_irq_o = rxi_p;
	assign ovr_irq_o = ovr_p;
	assign init_mode_acknowledge_o = init_ack;
	assign module_enable_bit_o = en;
	assign can_transmit_pin_o = txp;
	assign ack_drive_o = ackd;
	assign control_one_reg_o = ctl1;
	assign bus_timing_reg_zero_o = btr0;
	assign bus_timing_reg_one_o = btr1;
	assign acceptance_control_reg_o = idac;
	assign rx_err_cnt_o = rec;
	assign tx_err_cnt_o = tec;

	////////////////////////////////////////////////////////////////
	// checks
	property p_closed;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(fmode == crf_pkg::FMODE_CLOSED && cnt == 4'h0) |=> !hfull;
	endproperty
	a_closed: assert property (p_closed) else $error("closed mode set flag");

	property p_accept;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(accept && cnt == 4'h0) |=> hfull && (filter_hit_index_o == $past(f_idx));
	endproperty
	a_accept: assert property (p_accept) else $error("accepted frame not shown");

	property p_ovr;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(accept && cnt == 4'(DEPTH) && !pop) |=> ovr && cnt == 4'(DEPTH);
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun missed");

	property p_own;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(own_frame && !pop) |=> cnt <= $past(cnt);
	endproperty
	a_own: assert property (p_own) else $error("own frame stored");

	property p_lock;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!cfg_ok |=> $stable(btr0) && $stable(code) && $stable(mask) && $stable(ctl1)
			&& $stable(btr1) && $stable(idac);
	endproperty
	a_lock: assert property (p_lock) else $error("config changed while locked");

	property p_txrec;
		@(posedge mclk_i) disable iff (!rst_n_i)
		init_mode_request_i |=> can_transmit_pin_o;
	endproperty
	a_txrec: assert property (p_txrec) else $error("tx pin not recessive");

	property p_once;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(en_done && normal_sys_mode_i) |=> $stable(en);
	endproperty
	a_once: assert property (p_once) else $error("enable rewritten");

	property p_next;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(pop && cnt > 4'h1) |=> hfull;
	endproperty
	a_next: assert property (p_next) else $error("next frame not presented");

	property p_rej;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(!accept && !pop) |=> $stable(cnt);
	endproperty
	a_rej: assert property (p_rej) else $error("rejected frame stored");

	c_full: cover property (@(posedge mclk_i) cnt == 4'(DEPTH));
	c_ovr: cover property (@(posedge mclk_i) ovr_p);
	c_loop: cover property (@(posedge mclk_i) accept && loopb && tx_active_i);
endmodule

//--- inc/crf_pkg.sv
package crf_pkg;
	// fifo shape
	localparam int FIFO_DEPTH = 5;
	localparam int BUF_BYTES = 15;
	localparam int BUF_BITS = BUF_BYTES * 8;
	localparam int HIT_W = 3;
	localparam int NBANK_REGS = 8;
	// filter mode encodings of the acceptance control register
	localparam logic [1:0] FMODE_32 = 2'h0;
	localparam logic [1:0] FMODE_16 = 2'h1;
	localparam logic [1:0] FMODE_8 = 2'h2;
	localparam logic [1:0] FMODE_CLOSED = 2'h3;
	// config write select codes
	localparam logic [4:0] CSEL_CTL1 = 5'h00;
	localparam logic [4:0] CSEL_BTR0 = 5'h01;
	localparam logic [4:0] CSEL_BTR1 = 5'h02;
	localparam logic [4:0] CSEL_IDAC = 5'h03;
	localparam logic [4:0] CSEL_CODE0 = 5'h08;
	localparam logic [4:0] CSEL_MASK0 = 5'h10;
	// control one register bit positions
	localparam int CTL1_LOOPB = 5;
	localparam int CTL1_ENABLE = 7;
	// reset values
	localparam logic [7:0] CTL1_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'hff;
	// received frame header, as delivered by the bit engine
	typedef struct packed {
		logic [28:0] id;
		logic ide;
		logic rtr;
		logic srr;
	} crf_hdr_t;
	// one message buffer image plus its filter hit
	typedef struct packed {
		logic [BUF_BITS-1:0] data;
		logic [HIT_W-1:0] hit;
	} crf_entry_t;
	// config write strobe group
	typedef struct packed {
		logic we;
		logic [4:0] sel;
		logic [7:0] wdata;
	} crf_cfg_wr_t;
endpackage

//--- hdl/crf_filter.sv
`timescale 1ns/1ps
// identifier acceptance filter, purely combinational
module crf_filter (
	input wire logic [1:0] mode_i,
	input wire logic [63:0] code_i,
	input wire logic [63:0] mask_i,
	input wire crf_pkg::crf_hdr_t hdr_i,
	output logic hit_o,
	output logic [crf_pkg::HIT_W-1:0] idx_o
);
	////////////////////////////////////////////////////////////////
	// frame images in the 32-, 16- and 8-bit register layouts
	logic [31:0] img32; // extended or standard layout
	logic [15:0] img16; // 16-bit layout
	logic [7:0] img8; // first identifier byte
	logic [7:0] match; // per filter hit

	// masked compare: mask bit set means ignore
	function automatic logic cmp(input logic [31:0] v, input logic [31:0] c,
		input logic [31:0] m);
		cmp = ((v ^ c) & ~m) == 32'h0;
	endfunction

	////////////////////////////////////////////////////////////////
	// build layouts and compare per mode
	always_comb begin
		match = 8'h0;
		if (hdr_i.ide) begin
			img32 = {hdr_i.id[28:21], hdr_i.id[20:18], hdr_i.srr, hdr_i.ide,
				hdr_i.id[17:0], hdr_i.rtr};
			img16 = {hdr_i.id[28:21], hdr_i.id[20:18], hdr_i.srr, hdr_i.ide,
				hdr_i.id[17:15]};
			img8 = hdr_i.id[28:21];
		end else begin
			img32 = {hdr_i.id[10:0], hdr_i.rtr, hdr_i.ide, 19'h0};
			img16 = {hdr_i.id[10:0], hdr_i.rtr, hdr_i.ide, 3'h0};
			img8 = hdr_i.id[10:3];
		end
		unique case (mode_i)
			crf_pkg::FMODE_32: begin
				match[0] = cmp(img32, code_i[31:0], mask_i[31:0]);
				match[1] = cmp(img32, code_i[63:32], mask_i[63:32]);
			end
			crf_pkg::FMODE_16: begin
				for (int i = 0; i < 4; i++) begin
					match[i] = cmp({img16, 16'h0}, {code_i[i*16 +: 16], 16'h0},
						{mask_i[i*16 +: 16], 16'h0});
				end
			end
			crf_pkg::FMODE_8: begin
				for (int i = 0; i < 8; i++) begin
					match[i] = cmp({img8, 24'h0}, {code_i[i*8 +: 8], 24'h0},
						{mask_i[i*8 +: 8], 24'h0});
				end
			end
			crf_pkg::FMODE_CLOSED: begin
				match = 8'h0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// lowest numbered filter wins
	always_comb begin
		hit_o = |match;
		idx_o = '0;
		for (int i = 7; i >= 0; i--) begin
			if (match[i]) begin
				idx_o = 3'(i);
			end
		end
	end
endmodule

//--- hdl/crf_buffer.sv
`timescale 1ns/1ps
// private assembly buffer, written byte by byte while a frame arrives
module crf_buffer (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic sof_i,
	input wire logic byte_we_i,
	input wire logic [3:0] byte_idx_i,
	input wire logic [7:0] byte_i,
	output logic [crf_pkg::BUF_BITS-1:0] data_o
);
	////////////////////////////////////////////////////////////////
	logic [7:0] mem [crf_pkg::BUF_BYTES]; // byte store
	logic [7:0] next_mem [crf_pkg::BUF_BYTES];

	// next value: new frame clears, bytes overwrite
	always_comb begin
		next_mem = mem;
		if (sof_i) begin
			for (int i = 0; i < crf_pkg::BUF_BYTES; i++) begin
				next_mem[i] = crf_pkg::BYTE_RST;
			end
		end
		if (byte_we_i && (int'(byte_idx_i) < crf_pkg::BUF_BYTES)) begin
			next_mem[byte_idx_i] = byte_i;
		end
	end

	// register
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < crf_pkg::BUF_BYTES; i++) begin
				mem[i] <= crf_pkg::BYTE_RST;
			end
		end else begin
			mem <= next_mem;
		end
	end

	// flatten, byte 0 in low bits
	always_comb begin
		for (int i = 0; i < crf_pkg::BUF_BYTES; i++) begin
			data_o[i*8 +: 8] = mem[i];
		end
	end
endmodule

//--- tb/crf_frame_src.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// frame engine stand-in: delivers frames byte by byte
module crf_frame_src (
	input wire logic mclk_i,
	output logic sof_o,
	output logic byte_we_o,
	output logic [3:0] byte_idx_o,
	output logic [7:0] byte_o,
	output crf_pkg::crf_hdr_t hdr_o,
	output logic done_ok_o,
	output logic error_o,
	output logic tx_active_o,
	output logic arb_lost_o
);
	// idle bus, all-zero header so that code ff never matches
	initial begin
		sof_o = 1'b0;
		byte_we_o = 1'b0;
		byte_idx_o = 4'h0;
		byte_o = 8'h00;
		hdr_o = '0;
		done_ok_o = 1'b0;
		error_o = 1'b0;
		tx_active_o = 1'b0;
		arb_lost_o = 1'b0;
	end
	// one frame: start, fifteen bytes, then the end verdict
	task automatic send(input logic [7:0] tag, input logic err, input logic tx,
			input logic lost);
		@(negedge mclk_i);
		tx_active_o = tx;
		arb_lost_o = lost;
		sof_o = 1'b1;
		@(negedge mclk_i);
		sof_o = 1'b0;
		for (int i = 0; i < 15; i++) begin
			byte_we_o = 1'b1;
			byte_idx_o = i[3:0];
			byte_o = tag + i[7:0];
			@(negedge mclk_i);
		end
		byte_we_o = 1'b0;
		byte_o = ~byte_o; // released line shows no stale byte
		error_o = err;
		done_ok_o = 1'b1;
		@(negedge mclk_i);
		done_ok_o = 1'b0;
		error_o = 1'b0;
		tx_active_o = 1'b0;
		arb_lost_o = 1'b0;
		repeat (3) @(negedge mclk_i);
	endtask
endmodule

//--- tb/crf_top_test.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module crf_top_test;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sof, bwe, err, okd, txa, lost;
	logic [3:0] bidx;
	logic [7:0] bdat;
	crf_pkg::crf_hdr_t hdr;
	logic txb = 1'b1;
	logic ecwe = 1'b0;
	logic [7:0] ecwd = 8'h55;
	crf_pkg::crf_cfg_wr_t cfg = '0;
	logic idrq = 1'b0;
	logic pd = 1'b0;
	logic nsm = 1'b1;
	logic enwe = 1'b0;
	logic enwd = 1'b0;
	logic clr = 1'b0;
	logic rie = 1'b1;
	logic oie = 1'b1;
	logic [119:0] head;
	logic full, ovr, rirq, oirq, ack, en, pin, ackd;
	int n_ackd = 0;
	logic [2:0] hit;
	logic [7:0] c1, b0, b1, idac, rec, tec;
	int n_fail = 0;
	int n_compared = 0;
	int n_rirq = 0;
	int n_oirq = 0;
	int nb;
	logic [7:0] order [5] = '{8'h20, 8'h40, 8'h60, 8'h80, 8'hc0};

	always #5 mclk_i = ~mclk_i;
	// irq pulses last one cycle, so count them
	always @(posedge mclk_i) begin
		if (rirq === 1'b1) n_rirq++;
		if (oirq === 1'b1) n_oirq++;
		if (ackd === 1'b1) n_ackd++;
	end

	crf_frame_src src_u (.mclk_i(mclk_i), .sof_o(sof), .byte_we_o(bwe),
		.byte_idx_o(bidx), .byte_o(bdat), .hdr_o(hdr), .done_ok_o(okd),
		.error_o(err), .tx_active_o(txa), .arb_lost_o(lost));

	crf_top dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .rx_sof_i(sof),
		.rx_byte_we_i(bwe), .rx_byte_idx_i(bidx), .rx_byte_i(bdat), .rx_hdr_i(hdr),
		.rx_done_ok_i(okd), .rx_error_i(err), .tx_active_i(txa), .arb_lost_i(lost),
		.tx_bit_i(txb), .error_cnt_we_i(ecwe), .error_cnt_wdata_i(ecwd),
		.rx_err_inc_i(8'h00), .tx_err_inc_i(8'h00), .cfg_wr_i(cfg),
		.init_mode_request_i(idrq), .power_down_i(pd), .normal_sys_mode_i(nsm),
		.enable_we_i(enwe), .enable_wdata_i(enwd), .full_flag_clr_i(clr),
		.rx_int_en_i(rie), .ovr_int_en_i(oie), .cpu_visible_head_buffer_o(head),
		.receive_full_flag_o(full), .filter_hit_index_o(hit), .overrun_flag_o(ovr),
		.rx_irq_o(rirq), .ovr_irq_o(oirq), .init_mode_acknowledge_o(ack),
		.module_enable_bit_o(en), .can_transmit_pin_o(pin), .ack_drive_o(ackd),
		.control_one_reg_o(c1), .bus_timing_reg_zero_o(b0), .bus_timing_reg_one_o(b1),
		.acceptance_control_reg_o(idac), .rx_err_cnt_o(rec), .tx_err_cnt_o(tec));

	////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input string what, input logic [119:0] seen,
			input logic [119:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// expected buffer image of a frame with a given first byte
	function automatic logic [119:0] img(input logic [7:0] tag);
		for (int i = 0; i < 15; i++) img[8*i +: 8] = tag + i[7:0];
	endfunction
	// one config write strobe
	task automatic cfgw(input logic [4:0] sel, input logic [7:0] d);
		@(negedge mclk_i);
		cfg = {1'b1, sel, d};
		@(negedge mclk_i);
		cfg.we = 1'b0;
	endtask
	// request or leave init mode, let the acknowledge follow
	task automatic init_mode(input logic on);
		@(negedge mclk_i);
		idrq = on;
		repeat (3) @(negedge mclk_i);
	endtask
	// cpu releases the head buffer
	task automatic pop;
		@(negedge mclk_i);
		clr = 1'b1;
		@(negedge mclk_i);
		clr = 1'b0;
		@(negedge mclk_i);
	endtask
	// codes never match; masks open from the first byte of filter k on
	task automatic filt(input logic [1:0] m, input int bpf, input int k);
		init_mode(1'b1);
		cfgw(crf_pkg::CSEL_IDAC, {2'h0, m, 4'h0});
		for (int b = 0; b < 8; b++) begin
			cfgw(crf_pkg::CSEL_CODE0 + b[4:0], 8'hff);
			cfgw(crf_pkg::CSEL_MASK0 + b[4:0], (b >= k * bpf) ? 8'hff : 8'h00);
		end
		init_mode(1'b0);
	endtask
	// verdict
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		#200000;
		n_fail++;
		conclude();
	end

	// main sequence
	initial begin
		repeat (8) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_n_i = 1'b1;
		@(negedge mclk_i);
		chk("flag", full, 1'b0);
		chk("pin", pin, 1'b1);
		chk("ctl1", c1, crf_pkg::CTL1_RST);
		chk("idac", idac, 8'h00);
		// config locked outside init
		cfgw(crf_pkg::CSEL_IDAC, 8'h30);
		chk("idac locked", idac, 8'h00);
		// enable takes only the first write
		@(negedge mclk_i);
		{enwe, enwd} = 2'b11;
		@(negedge mclk_i);
		enwe = 1'b0;
		@(negedge mclk_i);
		{enwe, enwd} = 2'b10;
		@(negedge mclk_i);
		enwe = 1'b0;
		@(negedge mclk_i);
		chk("enable", en, 1'b1);
		// error counters ignore writes
		ecwe = 1'b1;
		@(negedge mclk_i);
		ecwe = 1'b0;
		@(negedge mclk_i);
		chk("rx err cnt", rec, 8'h00);
		chk("tx err cnt", tec, 8'h00);
		// pin follows the engine when online, recessive in init or power down
		txb = 1'b0;
		repeat (2) @(negedge mclk_i);
		chk("pin online", pin, 1'b0);
		init_mode(1'b1);
		chk("ack", ack, 1'b1);
		chk("pin init", pin, 1'b1);
		cfgw(crf_pkg::CSEL_IDAC, 8'h10);
		chk("idac open", idac, 8'h10);
		cfgw(crf_pkg::CSEL_BTR0, 8'h41);
		chk("btr0", b0, 8'h41);
		cfgw(crf_pkg::CSEL_BTR1, 8'h23);
		chk("btr1", b1, 8'h23);
		cfgw(crf_pkg::CSEL_IDAC, 8'h00);
		init_mode(1'b0);
		pd = 1'b1;
		repeat (2) @(negedge mclk_i);
		chk("pin pdown", pin, 1'b1);
		pd = 1'b0;
		txb = 1'b1;
		// plain accepted frame
		src_u.send(8'h10, 1'b0, 1'b0, 1'b0);
		chk("flag", full, 1'b1);
		chk("head", head, img(8'h10));
		chk("hit", hit, 3'h0);
		chk("rx irq", n_rirq, 1);
		pop();
		chk("flag clr", full, 1'b0);
		// bad frame then good one overwriting the private buffer
		src_u.send(8'h30, 1'b1, 1'b0, 1'b0);
		chk("bad frame", full, 1'b0);
		src_u.send(8'h50, 1'b0, 1'b0, 1'b0);
		chk("after bad", head, img(8'h50));
		pop();
		// own frame dropped, lost arbitration received
		nb = n_ackd;
		src_u.send(8'h70, 1'b0, 1'b1, 1'b0);
		chk("own frame", full, 1'b0);
		chk("own ack", n_ackd, nb);
		chk("own irq", n_rirq, 2);
		src_u.send(8'h90, 1'b0, 1'b1, 1'b1);
		chk("arb lost", head, img(8'h90));
		chk("arb ack", n_ackd, nb + 1);
		pop();
		// fill all stages, one more overruns
		for (int k = 0; k < 6; k++) src_u.send(8'h20 * k[7:0], 1'b0, 1'b0, 1'b0);
		// transmit path still follows the engine while the fifo is full
		txb = 1'b0;
		repeat (2) @(negedge mclk_i);
		chk("pin full", pin, 1'b0);
		txb = 1'b1;
		repeat (2) @(negedge mclk_i);
		chk("overrun", ovr, 1'b1);
		chk("ovr irq", n_oirq, 1);
		chk("oldest", head, img(8'h00));
		pop();
		chk("next head", head, img(8'h20));
		src_u.send(8'hc0, 1'b0, 1'b0, 1'b0);
		for (int k = 0; k < 5; k++) begin
			chk("drain", head, img(order[k]));
			chk("drain flag", full, 1'b1);
			pop();
		end
		chk("empty flag", full, 1'b0);
		chk("empty head", head, 120'h0);
		// loopback stores own frames
		init_mode(1'b1);
		cfgw(crf_pkg::CSEL_CTL1, 8'h20);
		chk("ctl1 loop", c1, 8'h20);
		init_mode(1'b0);
		src_u.send(8'h33, 1'b0, 1'b1, 1'b0);
		chk("loopback", head, img(8'h33));
		pop();
		// every filter of every open mode, lowest open one wins
		for (int m = 0; m < 3; m++) begin
			nb = 4 >> m;
			for (int k = 0; k < (8 / nb); k++) begin
				filt(m[1:0], nb, k);
				src_u.send(8'h44, 1'b0, 1'b0, 1'b0);
				chk("filter hit", hit, k[2:0]);
				chk("filter flag", full, 1'b1);
				pop();
			end
		end
		// all masks closed and codes wrong: nothing passes
		filt(crf_pkg::FMODE_32, 4, 2);
		src_u.send(8'h55, 1'b0, 1'b0, 1'b0);
		chk("no match", full, 1'b0);
		// closed mode rejects even with masks open
		filt(crf_pkg::FMODE_CLOSED, 1, 0);
		nb = n_rirq;
		src_u.send(8'h66, 1'b0, 1'b0, 1'b0);
		chk("closed", full, 1'b0);
		chk("closed irq", n_rirq, nb);
		conclude();
	end
endmodule
